// ==== logic/lpcc_top.sv ====
`timescale 1ns/1ps
module lpcc_top (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    // Register bus
    input  wire lpcc_pkg::lpcc_axi_req_t axiReq,
    output      lpcc_pkg::lpcc_axi_rsp_t axiRsp,
    // Wake sources
    input  wire logic                   extIrq,
    input  wire logic                   periphIrq,
    // Pins
    input  wire logic                   resetPinIn,
    output      lpcc_pkg::lpcc_pads_t    pads,
    output      logic [17:0]            slopeFast,
    // Clock gates and power
    output      logic                   cpuClkEn,
    output      logic [7:0]             perClkEn,
    output      logic                   lowPowerRegulator,
    output      logic                   wdgResetReq,
    output      logic                   resetPinReq
);
    import lpcc_pkg::*;

    typedef struct packed {
        logic [1:0]    rstPinSync;
        logic [1:0]    extIrqSync;
        logic [17:0]   hsiAcc;
        logic [17:0]   lsiAcc;
        logic [6:0]    divCnt;
        logic [2:0]    presc;
        logic          pa1AsOut;
        logic          pa1Val;
        logic [7:0]    pcken;
        logic [15:0]   awuPeriod;
        logic [15:0]   awuCnt;
        logic          wdgRun;
        logic [11:0]   wdgReload;
        logic [11:0]   wdgCnt;
        logic [17:0]   slope;
        lpcc_state_t   st;
        logic [7:0]    settleCnt;
        logic          regLowPower;
        logic          cpuClkEn;
        logic [7:0]    perClkEn;
        logic          wdgResetReq;
        logic          resetPinReq;
        lpcc_pads_t    pads;
        logic          awHave;
        logic [7:0]    awAddr;
        logic          wHave;
        logic [31:0]   wData;
        logic [3:0]    wStrb;
        lpcc_axi_rsp_t rsp;
    } lpcc_top_state_t;

    logic [1:0]       rstSync_reg;
    logic             rstN;
    lpcc_top_state_t  s_reg;
    lpcc_top_state_t  s_next;
    logic             hsiTick;
    logic             lsiTick;
    logic             sysTick;
    logic [6:0]       divMask;
    logic [18:0]      hsiStep;
    logic [18:0]      lsiStep;

    // Fractional step: adds rate per cycle, ticks on wrap
    function automatic logic [18:0] fracStep(input logic [17:0] acc,
                                             input int rateKhz);
        logic [18:0] sum;
        sum = {1'b0, acc} + 19'(rateKhz);
        if (sum >= 19'(CORE_KHZ)) begin
            fracStep = {1'b1, 18'(sum - 19'(CORE_KHZ))};
        end else begin
            fracStep = {1'b0, sum[17:0]};
        end
    endfunction

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        mergeBytes = res;
    endfunction

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstN = rstSync_reg[1];

    // Oscillator ticks and prescaled system clock enable
    assign hsiStep = fracStep(s_reg.hsiAcc, HSI_KHZ);
    assign lsiStep = fracStep(s_reg.lsiAcc, LSI_KHZ);
    assign hsiTick = hsiStep[18];
    assign lsiTick = lsiStep[18];
    assign divMask = 7'((8'h01 << s_reg.presc) - 8'h01);
    assign sysTick = hsiTick && ((s_reg.divCnt & divMask) == divMask);

    // Next state of the whole block
    always_comb begin
        logic [31:0] cur;
        logic        doWrite;
        cur = 32'h0;
        doWrite = 1'b0;
        s_next = s_reg;
        s_next.rstPinSync = {s_reg.rstPinSync[0], resetPinIn};
        s_next.extIrqSync = {s_reg.extIrqSync[0], extIrq};
        s_next.hsiAcc = hsiStep[17:0];
        s_next.lsiAcc = lsiStep[17:0];
        if (hsiTick) begin
            s_next.divCnt = s_reg.divCnt + 7'h01;
        end

        // Gated enables per destination
        s_next.cpuClkEn = sysTick && (s_reg.st == ST_RUN);
        for (int i = 0; i < 8; i++) begin
            s_next.perClkEn[i] = sysTick && s_reg.pcken[i] &&
                ((s_reg.st == ST_RUN) || (s_reg.st == ST_WAIT));
        end

        // Watchdog on the slow tick, whatever the mode
        s_next.wdgResetReq = 1'b0;
        if (s_reg.wdgRun && lsiTick) begin
            if (s_reg.wdgCnt == 12'h000) begin
                s_next.wdgResetReq = 1'b1;
                s_next.wdgCnt = s_reg.wdgReload;
            end else begin
                s_next.wdgCnt = s_reg.wdgCnt - 12'h001;
            end
        end

        // Pads after reset release
        s_next.pads.pb0Pullup = 1'b0;
        s_next.pads.pb4Pullup = 1'b0;
        s_next.pads.pa0Pullup = 1'b1;
        s_next.pads.pa1Oe = s_reg.pa1AsOut;
        s_next.pads.pa1Out = s_reg.pa1Val;
        s_next.pads.pa1Pullup = !s_reg.pa1AsOut;
        s_next.resetPinReq = !s_reg.pa1AsOut && !s_reg.rstPinSync[1];

        // Power mode sequencing
        unique case (s_reg.st)
            ST_RUN: begin
            end
            ST_WAIT: begin
                if (s_reg.extIrqSync[1] || periphIrq) begin
                    s_next.st = ST_RUN;
                end
            end
            ST_AHALT: begin
                if (s_reg.awuCnt == 16'h0000 || s_reg.extIrqSync[1]) begin
                    s_next.st = ST_WAKE;
                    s_next.settleCnt = 8'h00;
                end else if (lsiTick) begin
                    s_next.awuCnt = s_reg.awuCnt - 16'h0001;
                end
            end
            ST_HALT: begin
                if (s_reg.extIrqSync[1]) begin
                    s_next.st = ST_WAKE;
                    s_next.settleCnt = 8'h00;
                end
            end
            ST_WAKE: begin
                s_next.regLowPower = 1'b0;
                if (s_reg.settleCnt >= 8'(REG_SETTLE_CYC - 1)) begin
                    s_next.st = ST_RUN;
                end else begin
                    s_next.settleCnt = s_reg.settleCnt + 8'h01;
                end
            end
        endcase

        // Bus: address and data taken in either order
        if (axiReq.awvalid && s_reg.rsp.awready) begin
            s_next.awHave = 1'b1;
            s_next.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_reg.rsp.wready) begin
            s_next.wHave = 1'b1;
            s_next.wData = axiReq.wdata;
            s_next.wStrb = axiReq.wstrb;
        end
        if (s_reg.rsp.bvalid && axiReq.bready) begin
            s_next.rsp.bvalid = 1'b0;
        end
        doWrite = s_reg.awHave && s_reg.wHave && !s_reg.rsp.bvalid;
        if (doWrite) begin
            s_next.awHave = 1'b0;
            s_next.wHave = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp = RESP_OKAY;
            unique case ({s_reg.awAddr[7:2], 2'b00})
                OFS_CTRL: begin
                    cur = mergeBytes({27'h0, s_reg.pa1Val, s_reg.pa1AsOut,
                        s_reg.presc}, s_reg.wData, s_reg.wStrb);
                    s_next.presc = cur[CTRL_PRESC_LSB +: 3];
                    s_next.pa1AsOut = cur[CTRL_PA1OUT];
                    s_next.pa1Val = cur[CTRL_PA1VAL];
                end
                OFS_PCKEN: begin
                    cur = mergeBytes({24'h0, s_reg.pcken}, s_reg.wData,
                        s_reg.wStrb);
                    s_next.pcken = cur[7:0];
                end
                OFS_MODE: begin
                    if (s_reg.st == ST_RUN && s_reg.wStrb[0]) begin
                        unique case (lpcc_cmd_t'(s_reg.wData[1:0]))
                            CMD_NONE: begin
                            end
                            CMD_WAIT: begin
                                s_next.st = ST_WAIT;
                            end
                            CMD_AHALT: begin
                                s_next.st = ST_AHALT;
                                s_next.regLowPower = 1'b1;
                                s_next.awuCnt = s_reg.awuPeriod;
                            end
                            CMD_HALT: begin
                                s_next.st = ST_HALT;
                                s_next.regLowPower = 1'b1;
                            end
                        endcase
                    end
                end
                OFS_AWU: begin
                    cur = mergeBytes({16'h0, s_reg.awuPeriod}, s_reg.wData,
                        s_reg.wStrb);
                    s_next.awuPeriod = cur[15:0];
                end
                OFS_WDGRLD: begin
                    cur = mergeBytes({20'h0, s_reg.wdgReload}, s_reg.wData,
                        s_reg.wStrb);
                    s_next.wdgReload = cur[11:0];
                end
                OFS_WDGKEY: begin
                    if (s_reg.wStrb[0] && s_reg.wData[7:0] == KEY_START) begin
                        s_next.wdgRun = 1'b1;
                        s_next.wdgCnt = s_reg.wdgReload;
                    end else if (s_reg.wStrb[0] &&
                                 s_reg.wData[7:0] == KEY_REFRESH) begin
                        s_next.wdgCnt = s_reg.wdgReload;
                    end
                end
                OFS_SLOPE: begin
                    cur = mergeBytes({14'h0, s_reg.slope}, s_reg.wData,
                        s_reg.wStrb);
                    s_next.slope = cur[17:0] & ~OD_MASK;
                end
                OFS_STATUS: begin
                end
                default: begin
                    s_next.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end
        s_next.rsp.awready = !s_next.awHave;
        s_next.rsp.wready = !s_next.wHave;

        // Bus: read path
        if (s_reg.rsp.rvalid && axiReq.rready) begin
            s_next.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && s_reg.rsp.arready) begin
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rresp = RESP_OKAY;
            s_next.rsp.rdata = 32'h0;
            unique case ({axiReq.araddr[7:2], 2'b00})
                OFS_CTRL: s_next.rsp.rdata = {27'h0, s_reg.pa1Val,
                    s_reg.pa1AsOut, s_reg.presc};
                OFS_PCKEN:  s_next.rsp.rdata = {24'h0, s_reg.pcken};
                OFS_MODE:   s_next.rsp.rdata = {29'h0, s_reg.st};
                OFS_AWU:    s_next.rsp.rdata = {16'h0, s_reg.awuPeriod};
                OFS_WDGRLD: s_next.rsp.rdata = {20'h0, s_reg.wdgReload};
                OFS_WDGKEY: s_next.rsp.rdata = 32'h0;
                OFS_SLOPE:  s_next.rsp.rdata = {14'h0, s_reg.slope};
                OFS_STATUS: begin
                    s_next.rsp.rdata[STAT_REGLP] = s_reg.regLowPower;
                    s_next.rsp.rdata[STAT_WDGRUN] = s_reg.wdgRun;
                    s_next.rsp.rdata[STAT_ST_LSB +: 3] = s_reg.st;
                    s_next.rsp.rdata[STAT_WDGCNT_LSB +: 12] = s_reg.wdgCnt;
                end
                default: s_next.rsp.rresp = RESP_SLVERR;
            endcase
        end
        s_next.rsp.arready = !s_next.rsp.rvalid;
    end

    // State register; pads hold reset-phase pulls
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            s_reg <= '0;
            s_reg.presc <= PRESC_RST;
            s_reg.pcken <= PCKEN_RST;
            s_reg.awuPeriod <= AWU_RST;
            s_reg.wdgReload <= WDGRLD_RST;
            s_reg.wdgCnt <= WDGRLD_RST;
            s_reg.slope <= SLOPE_RST;
            s_reg.st <= ST_RUN;
            s_reg.rstPinSync <= 2'h3;
            s_reg.pads.pa1Pullup <= 1'b1;
            s_reg.pads.pa0Pullup <= 1'b1;
            s_reg.pads.pb0Pullup <= 1'b1;
            s_reg.pads.pb4Pullup <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign axiRsp = s_reg.rsp;
    assign pads = s_reg.pads;
    assign slopeFast = s_reg.slope;
    assign cpuClkEn = s_reg.cpuClkEn;
    assign perClkEn = s_reg.perClkEn;
    assign lowPowerRegulator = s_reg.regLowPower;
    assign wdgResetReq = s_reg.wdgResetReq;
    assign resetPinReq = s_reg.resetPinReq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstN);

    // Checks on modes, clocks and pads
    a_wait_cpu_off: assert property (
        s_reg.st == ST_WAIT && $past(s_reg.st) == ST_WAIT |-> !cpuClkEn)
        else $error("cpu clock ran in wait");
    a_wait_per_on: assert property (
        $past(sysTick) && $past(s_reg.pcken[0]) &&
        $past(s_reg.st) == ST_WAIT |-> perClkEn[0])
        else $error("peripheral clock lost in wait");
    a_halt_clks_off: assert property (
        (s_reg.st == ST_AHALT || s_reg.st == ST_HALT) &&
        ($past(s_reg.st) == ST_AHALT || $past(s_reg.st) == ST_HALT)
        |-> !cpuClkEn && perClkEn == 8'h00)
        else $error("clock ran in halt");
    a_halt_ext_only: assert property (
        s_reg.st == ST_HALT && !s_reg.extIrqSync[1] |=> s_reg.st == ST_HALT)
        else $error("halt left without interrupt");
    a_awu_wake_time: assert property (
        s_reg.st == ST_AHALT && s_reg.awuCnt == 16'h0000
        |=> s_reg.st == ST_WAKE)
        else $error("active halt missed wakeup");
    a_lp_on_entry: assert property (
        s_reg.st == ST_RUN ##1 (s_reg.st == ST_AHALT || s_reg.st == ST_HALT)
        |-> lowPowerRegulator)
        else $error("regulator not low power");
    a_reg_before_clk: assert property (
        s_reg.st == ST_WAKE ##1 s_reg.st == ST_RUN
        |-> !lowPowerRegulator && !$past(lowPowerRegulator))
        else $error("clocks back before regulator");
    a_wdg_expiry: assert property (
        s_reg.wdgRun && s_reg.wdgCnt == 12'h000 && lsiTick
        |=> wdgResetReq ##1 !wdgResetReq)
        else $error("watchdog expiry lost");
    a_pb_float_after: assert property (
        $past(rstN) |-> !pads.pb0Pullup && !pads.pb4Pullup && pads.pa0Pullup)
        else $error("port pulls wrong after reset");
    a_pa1_pushpull: assert property (
        pads.pa1Oe |-> !pads.pa1Pullup)
        else $error("reset pin output with pull-up");
    a_slope_od_off: assert property (
        (slopeFast & OD_MASK) == 18'h00000)
        else $error("slope set on open drain pin");

    c_wait_wake: cover property (
        s_reg.st == ST_WAIT ##1 s_reg.st == ST_RUN);
    c_ahalt_wake: cover property (
        s_reg.st == ST_AHALT ##1 s_reg.st == ST_WAKE);
    c_halt_wake: cover property (
        s_reg.st == ST_HALT ##1 s_reg.st == ST_WAKE);
    c_wdg_fire: cover property (wdgResetReq);

endmodule // lpcc_top

// ==== logic/lpcc_pkg.sv ====
package lpcc_pkg;

    // Clock rates in kHz
    localparam int CORE_KHZ = 250000;
    localparam int HSI_KHZ  = 16000;
    localparam int LSI_KHZ  = 38;

    // Regulator settling before clocks return, least time
    localparam int REG_SETTLE_NS  = 100;
    localparam int REG_SETTLE_CYC =
        (REG_SETTLE_NS * (CORE_KHZ / 1000) + 999) / 1000;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PCKEN  = 8'h04;
    localparam logic [7:0] OFS_MODE   = 8'h08;
    localparam logic [7:0] OFS_AWU    = 8'h0C;
    localparam logic [7:0] OFS_WDGRLD = 8'h10;
    localparam logic [7:0] OFS_WDGKEY = 8'h14;
    localparam logic [7:0] OFS_SLOPE  = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // Field positions
    localparam int CTRL_PRESC_LSB = 0;
    localparam int CTRL_PA1OUT    = 3;
    localparam int CTRL_PA1VAL    = 4;
    localparam int STAT_REGLP     = 0;
    localparam int STAT_WDGRUN    = 1;
    localparam int STAT_ST_LSB    = 4;
    localparam int STAT_WDGCNT_LSB = 16;

    // Reset values
    localparam logic [2:0]  PRESC_RST  = 3'h0;
    localparam logic [7:0]  PCKEN_RST  = 8'h00;
    localparam logic [15:0] AWU_RST    = 16'h0026;
    localparam logic [11:0] WDGRLD_RST = 12'hFFF;
    localparam logic [17:0] SLOPE_RST  = 18'h00000;
    // Pins that are true open drain have no slope control
    localparam logic [17:0] OD_MASK    = 18'h00000;

    // Watchdog keys
    localparam logic [7:0] KEY_START   = 8'hCC;
    localparam logic [7:0] KEY_REFRESH = 8'hAA;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Mode commands written to the mode register
    typedef enum logic [1:0] {
        CMD_NONE  = 2'b00,
        CMD_WAIT  = 2'b01,
        CMD_AHALT = 2'b10,
        CMD_HALT  = 2'b11
    } lpcc_cmd_t;

    // Power mode states
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_WAIT  = 3'b001,
        ST_AHALT = 3'b010,
        ST_HALT  = 3'b011,
        ST_WAKE  = 3'b100
    } lpcc_state_t;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } lpcc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } lpcc_axi_rsp_t;

    // Pad controls for reset pin and pulled-up port pins
    typedef struct packed {
        logic pa1Out;
        logic pa1Oe;
        logic pa1Pullup;
        logic pa0Pullup;
        logic pb0Pullup;
        logic pb4Pullup;
    } lpcc_pads_t;

endpackage

// ==== testbench/lpcc_periph_model.sv ====
`timescale 1ns/1ps
// Core and peripherals that consume the clock ticks
module lpcc_periph_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Ticks in, counter clear from bench
    input  wire logic       cpuClkEn,
    input  wire logic [7:0] perClkEn,
    input  wire logic       clr,
    // Peripheral interrupt
    input  wire logic       raiseIrq,
    output      logic       periphIrq
);
    int         cpuCnt;
    logic [7:0] perSeen;

    // Count core ticks, note which peripherals got ticks
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpuCnt    <= 0;
            perSeen   <= 8'h00;
            periphIrq <= 1'b0;
        end else begin
            cpuCnt    <= clr ? 0 : cpuCnt + int'(cpuClkEn);
            perSeen   <= clr ? 8'h00 : (perSeen | perClkEn);
            periphIrq <= raiseIrq;
        end
    end
endmodule // lpcc_periph_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
    import lpcc_pkg::*;
    logic core_clk, rst_b, extIrq, resetPinIn, clr, raiseIrq, periphIrq;
    logic cpuClkEn, lpReg, wdgReq, pinReq;
    logic [7:0] perClkEn, pck;
    logic [17:0] slopeFast;
    lpcc_axi_req_t req;
    lpcc_axi_rsp_t axiRsp, rs;
    lpcc_pads_t pads;
    logic [31:0] q0, d0;
    logic [1:0] r0;
    int n_errors = 0, num_checks = 0, n, p;

    lpcc_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .axiReq(req),
        .axiRsp(axiRsp), .extIrq(extIrq), .periphIrq(periphIrq),
        .resetPinIn(resetPinIn), .pads(pads), .slopeFast(slopeFast),
        .cpuClkEn(cpuClkEn), .perClkEn(perClkEn),
        .lowPowerRegulator(lpReg), .wdgResetReq(wdgReq),
        .resetPinReq(pinReq));
    lpcc_periph_model u_per (.core_clk(core_clk), .rst_b(rst_b),
        .cpuClkEn(cpuClkEn), .perClkEn(perClkEn), .clr(clr),
        .raiseIrq(raiseIrq), .periphIrq(periphIrq));

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Bus answer as seen at the next rising edge
    always @(negedge core_clk) rs <= axiRsp;

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One AXI4-Lite write or read, bounded wait
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge core_clk);
        req.awaddr <= a;
        req.araddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        {req.awvalid, req.wvalid, req.bready} <= {3{wr}};
        {req.arvalid, req.rready} <= {2{!wr}};
        for (i = 0; i < 100; i++) begin
            @(posedge core_clk);
            if (rs.awready) req.awvalid <= 1'b0;
            if (rs.wready) req.wvalid <= 1'b0;
            if (rs.arready) req.arvalid <= 1'b0;
            if (wr ? rs.bvalid : rs.rvalid) break;
        end
        req.bready <= 1'b0;
        req.rready <= 1'b0;
        q0 = rs.rdata;
        r0 = wr ? rs.bresp : rs.rresp;
        if (i == 100) begin
            n_errors++;
            give_verdict;
        end
    endtask
    task automatic tick(int k);
        repeat (k) @(negedge core_clk);
    endtask
    // Strobe for k cycles: 0 count clear, 1 peripheral irq, 2 external irq
    task automatic pulse(int w, int k);
        @(posedge core_clk);
        clr <= (w == 0);
        raiseIrq <= (w == 1);
        extIrq <= (w == 2);
        repeat (k) @(posedge core_clk);
        {clr, raiseIrq, extIrq} <= 3'h0;
    endtask
    // Wait for regulator back to main (k=0) or watchdog pulse (k=1)
    task automatic waitFor(int k, int lim);
        for (n = 0; n < lim; n++) begin
            @(negedge core_clk);
            if (k == 0 ? lpReg === 1'b0 : wdgReq === 1'b1) break;
        end
        if (n == lim) begin
            n_errors++;
            give_verdict;
        end
    endtask
    function automatic logic [31:0] inRange(int v, int lo, int hi);
        return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
    endfunction

    // Main sequence
    initial begin
        void'($urandom(32'h5A29));
        {rst_b, extIrq, clr, raiseIrq} = 4'h0;
        resetPinIn = 1'b1;
        req = '0;
        repeat (5) @(posedge core_clk);
        tick(1);
        chk("pullRst", 4'hF, {pads.pa1Pullup, pads.pa0Pullup,
            pads.pb0Pullup, pads.pb4Pullup});
        @(posedge core_clk);
        rst_b <= 1'b1;
        tick(6);
        chk("pullRun", 4'hC, {pads.pa1Pullup, pads.pa0Pullup,
            pads.pb0Pullup, pads.pb4Pullup});
        chk("slopeRst", 0, slopeFast);
        bus(0, OFS_SLOPE, 0);
        chk("slopeReg", {14'h0, SLOPE_RST}, q0);
        bus(0, OFS_AWU, 0);
        chk("awuReg", {16'h0, AWU_RST}, q0);
        bus(0, 8'h20, 0);
        chk("unmapped", {30'h0, RESP_SLVERR}, {q0[29:0], r0});
        d0 = $urandom & 32'h3FFFF;
        bus(1, OFS_SLOPE, d0);
        tick(3);
        chk("slopeSet", d0 & ~{14'h0, OD_MASK}, slopeFast);
        $display("test reset and registers done");
        // Prescaler: 2500 cycles carry 160 ticks of 16 MHz
        for (int j = 0; j < 3; j++) begin
            p = (j == 2) ? int'($urandom_range(7, 1)) : 2 * j;
            bus(1, OFS_CTRL, p);
            pulse(0, 1);
            tick(2500);
            chk("ticks", 1, inRange(u_per.cpuCnt, (160 >> p) - 1,
                (160 >> p) + 1));
        end
        $display("test prescaler done");
        bus(1, OFS_CTRL, 0);
        pck = 8'($urandom) | 8'h01;
        bus(1, OFS_PCKEN, {24'h0, pck});
        bus(1, OFS_MODE, CMD_WAIT);
        pulse(0, 1);
        tick(200);
        chk("waitCpu", 0, u_per.cpuCnt);
        chk("waitPer", pck, u_per.perSeen);
        pulse(1, 4);
        pulse(0, 1);
        tick(100);
        chk("waitWake", 1, inRange(u_per.cpuCnt, 1, 200));
        $display("test wait done");
        bus(1, OFS_MODE, CMD_HALT);
        pulse(0, 1);
        tick(200);
        chk("haltReg", 1, lpReg);
        chk("haltClk", 0, u_per.cpuCnt + u_per.perSeen);
        pulse(1, 20);
        tick(50);
        chk("haltStay", 1, lpReg);
        bus(0, OFS_STATUS, 0);
        chk("haltStat", {4'h0, WDGRLD_RST, 9'h0, ST_HALT, 4'h1}, q0);
        pulse(2, 4);
        waitFor(0, 100);
        chk("regFirst", 0, u_per.cpuCnt);
        tick(100);
        chk("haltWake", 1, inRange(u_per.cpuCnt, 1, 200));
        $display("test halt done");
        bus(1, OFS_AWU, 2);
        bus(1, OFS_MODE, CMD_AHALT);
        tick(2);
        chk("ahaltReg", 1, lpReg);
        waitFor(0, 20000);
        chk("ahaltTime", 1, inRange(n, 6400, 13400));
        $display("test active halt done");
        bus(1, OFS_CTRL, 32'h18);
        tick(3);
        chk("pa1Out", 2'b11, {pads.pa1Oe, pads.pa1Out});
        bus(1, OFS_CTRL, 0);
        @(posedge core_clk);
        resetPinIn <= 1'b0;
        tick(6);
        chk("pinReq", 3'b101, {pinReq, pads.pa1Oe, pads.pa1Pullup});
        @(posedge core_clk);
        resetPinIn <= 1'b1;
        $display("test reset pin done");
        bus(1, OFS_WDGRLD, 2);
        bus(1, OFS_WDGKEY, {24'h0, KEY_START});
        bus(1, OFS_MODE, CMD_HALT);
        waitFor(1, 20000);
        chk("wdgHalt", 1, inRange(n, 2 * (CORE_KHZ / LSI_KHZ) - 20,
            3 * (CORE_KHZ / LSI_KHZ) + 20));
        pulse(2, 4);
        $display("test watchdog done");
        give_verdict;
    end
endmodule // tb
